// ==== inc/sarseq_pkg.sv ====
// Package for the SAR converter sequencer: offsets, fields, codes, timing
package sarseq_pkg;
    localparam logic [3:0] SARSEQ_OFS_CTRL1 = 4'h0;
    localparam logic [3:0] SARSEQ_OFS_CTRL2 = 4'h2;
    localparam logic [3:0] SARSEQ_OFS_CTRL3 = 4'h4;
    localparam logic [3:0] SARSEQ_OFS_IRQ = 4'h6;
    localparam logic [3:0] SARSEQ_OFS_BUF = 4'h8;
    localparam logic [15:0] SARSEQ_CTRL1_RST = 16'h0000;
    localparam logic [15:0] SARSEQ_CTRL2_RST = 16'h0000;
    localparam logic [15:0] SARSEQ_CTRL3_RST = 16'h0000;
    localparam logic [15:0] SARSEQ_CTRL1_WMASK = 16'ha3e7;
    localparam logic [15:0] SARSEQ_CTRL2_WMASK = 16'he43f;
    localparam logic [15:0] SARSEQ_CTRL3_WMASK = 16'h9fff;
    localparam int SARSEQ_B_ON = 15;
    localparam int SARSEQ_B_IDLE = 13;
    localparam int SARSEQ_B_AUTO_SAMPLE_START = 2;
    localparam int SARSEQ_B_SAMPLE_ACTIVE = 1;
    localparam int SARSEQ_B_DONE = 0;
    localparam int SARSEQ_B_SCAN = 10;
    localparam int SARSEQ_B_FILL = 7;
    localparam int SARSEQ_B_SPLIT = 1;
    localparam int SARSEQ_B_ALT = 0;
    localparam int SARSEQ_B_RC = 15;
    localparam logic [2:0] SARSEQ_TRIG_MANUAL = 3'h0;
    localparam logic [2:0] SARSEQ_TRIG_EXT = 3'h1;
    localparam logic [2:0] SARSEQ_TRIG_T3 = 3'h2;
    localparam logic [2:0] SARSEQ_TRIG_T5 = 3'h4;
    localparam logic [2:0] SARSEQ_TRIG_CTU = 3'h6;
    localparam logic [2:0] SARSEQ_TRIG_AUTO = 3'h7;
    localparam logic [7:0] SARSEQ_DIV_MAX = 8'h3f;
    localparam int SARSEQ_CONV_TADS = 12;
    localparam int SARSEQ_RES_W = 10;
    typedef enum logic [1:0] {
        SARSEQ_FMT_INT = 2'h0,
        SARSEQ_FMT_SINT = 2'h1,
        SARSEQ_FMT_FRAC = 2'h2,
        SARSEQ_FMT_SFRAC = 2'h3
    } sarseq_fmt_e;
    typedef enum logic [1:0] {
        SARSEQ_ST_OFF = 2'b00,
        SARSEQ_ST_HOLD = 2'b01,
        SARSEQ_ST_SAMPLE = 2'b11,
        SARSEQ_ST_CONVERT = 2'b10
    } sarseq_state_e;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sarseq_bus_s;
    typedef struct packed {
        logic timer_three;
        logic timer_five;
        logic charge_time_unit;
        logic external_interrupt_pin;
    } sarseq_trig_s;
endpackage : sarseq_pkg

// ==== hdl/sarseq_top.sv ====
// SAR converter sequencer: control registers, timing, buffer, formatting
`timescale 1ns/1ps
module sarseq_top
    import sarseq_pkg::*;
#(
    parameter int BUF_DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire sarseq_bus_s bus_i,
    output logic [15:0] rdata_o,
    input wire sarseq_trig_s trig_i,
    input wire logic device_idle_i,
    input wire logic rc_tick_i,
    input wire logic [SARSEQ_RES_W-1:0] sar_result_i,
    output logic sample_o,
    output logic use_mux_b_o,
    output logic scan_step_o,
    output logic [1:0] vref_pos_neg_o,
    output logic conversion_irq_flag_o
);
    initial begin
        if (BUF_DEPTH != 16) begin
            $error("BUF_DEPTH must be 16");
        end
    end

    logic [15:0] ctrl1_q;
    logic [15:0] ctrl2_q;
    logic [15:0] ctrl3_q;
    logic [15:0] buf_q [BUF_DEPTH];
    logic [3:0] wptr_q;
    logic fill_q;
    logic [3:0] seq_cnt_q;
    logic irq_q;
    logic alt_b_q;
    logic [7:0] div_q;
    logic [4:0] tad_cnt_q;
    sarseq_state_e st_q;
    logic [15:0] rdata_q;
    logic ext_q;

    wire sel_c1 = bus_i.addr == SARSEQ_OFS_CTRL1;
    wire sel_c2 = bus_i.addr == SARSEQ_OFS_CTRL2;
    wire sel_c3 = bus_i.addr == SARSEQ_OFS_CTRL3;
    wire sel_irq = bus_i.addr == SARSEQ_OFS_IRQ;
    wire sel_buf = bus_i.addr[3];
    wire module_on = ctrl1_q[SARSEQ_B_ON];
    // Idle stop freezes sequencing but keeps registers
    wire run = module_on && !(ctrl1_q[SARSEQ_B_IDLE] && device_idle_i);
    wire [1:0] result_format = ctrl1_q[9:8];
    wire [2:0] trigger_source_select = ctrl1_q[7:5];
    wire auto_sample_start = ctrl1_q[SARSEQ_B_AUTO_SAMPLE_START];
    wire [2:0] reference_select = ctrl2_q[15:13];
    wire split_buffer_mode = ctrl2_q[SARSEQ_B_SPLIT];
    wire [3:0] sequences_per_interrupt = ctrl2_q[5:2];
    wire conv_clock_source = ctrl3_q[SARSEQ_B_RC];
    wire [4:0] sample_time_count = ctrl3_q[12:8];
    wire [7:0] conv_clock_divider = ctrl3_q[7:0];
    // Reserved divider codes clamp to the longest legal period
    wire [7:0] div_lim = (conv_clock_divider > SARSEQ_DIV_MAX) ?
        SARSEQ_DIV_MAX : conv_clock_divider;
    wire sys_tick = div_q == div_lim;
    wire tad_tick = conv_clock_source ? rc_tick_i : sys_tick;

    wire ext_edge = trig_i.external_interrupt_pin && !ext_q;
    logic trig_hit;
    always_comb begin
        unique case (trigger_source_select)
            SARSEQ_TRIG_EXT: trig_hit = ext_edge;
            SARSEQ_TRIG_T3: trig_hit = trig_i.timer_three;
            SARSEQ_TRIG_T5: trig_hit = trig_i.timer_five;
            SARSEQ_TRIG_CTU: trig_hit = trig_i.charge_time_unit;
            SARSEQ_TRIG_AUTO: trig_hit = tad_tick &&
                tad_cnt_q >= sample_time_count;
            default: trig_hit = 1'b0;
        endcase
    end

    wire w_c1 = bus_i.wr && sel_c1;
    wire sw_sample_active_set = w_c1 && bus_i.wdata[SARSEQ_B_SAMPLE_ACTIVE];
    wire sw_sample_active_clr = w_c1 && !bus_i.wdata[SARSEQ_B_SAMPLE_ACTIVE];
    // Manual mode ends sampling on a software clear
    wire end_sample = st_q == SARSEQ_ST_SAMPLE && (trig_hit ||
        (trigger_source_select == SARSEQ_TRIG_MANUAL && sw_sample_active_clr));
    // Gated by run: a free-running tick must not finish a frozen conversion
    wire conv_done = run && st_q == SARSEQ_ST_CONVERT && tad_tick &&
        tad_cnt_q == 5'(SARSEQ_CONV_TADS - 1);
    wire seq_last = seq_cnt_q == sequences_per_interrupt;
    wire irq_event = conv_done && seq_last;

    logic [15:0] fmt_word;
    always_comb begin
        unique case (sarseq_fmt_e'(result_format))
            SARSEQ_FMT_INT: fmt_word = {6'h00, sar_result_i};
            SARSEQ_FMT_SINT: fmt_word = {{7{!sar_result_i[9]}},
                sar_result_i[8:0]};
            SARSEQ_FMT_FRAC: fmt_word = {sar_result_i, 6'h00};
            SARSEQ_FMT_SFRAC: fmt_word = {!sar_result_i[9],
                sar_result_i[8:0], 6'h00};
        endcase
    end

    wire [3:0] half_base = {split_buffer_mode & fill_q, 3'h0};
    wire [3:0] waddr = half_base | wptr_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 8'h00;
            ext_q <= 1'b0;
        end else begin
            div_q <= (sys_tick || !run) ? 8'h00 : div_q + 8'h01;
            ext_q <= trig_i.external_interrupt_pin;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= SARSEQ_ST_OFF;
            tad_cnt_q <= 5'h00;
        end else if (!module_on) begin
            st_q <= SARSEQ_ST_OFF;
            tad_cnt_q <= 5'h00;
        end else if (run) begin
            unique case (st_q)
                SARSEQ_ST_OFF: st_q <= SARSEQ_ST_HOLD;
                SARSEQ_ST_HOLD: begin
                    tad_cnt_q <= 5'h00;
                    if (sw_sample_active_set) st_q <= SARSEQ_ST_SAMPLE;
                end
                SARSEQ_ST_SAMPLE: begin
                    if (end_sample) begin
                        st_q <= SARSEQ_ST_CONVERT;
                        tad_cnt_q <= 5'h00;
                    end else if (sw_sample_active_clr) begin
                        st_q <= SARSEQ_ST_HOLD;
                    end else if (tad_tick && tad_cnt_q != 5'h1f) begin
                        tad_cnt_q <= tad_cnt_q + 5'h01;
                    end
                end
                SARSEQ_ST_CONVERT: begin
                    if (conv_done) begin
                        tad_cnt_q <= 5'h00;
                        st_q <= auto_sample_start ? SARSEQ_ST_SAMPLE :
                            SARSEQ_ST_HOLD;
                    end else if (tad_tick) begin
                        tad_cnt_q <= tad_cnt_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // Done bit: hardware set wins over a software clear
    wire done_set = conv_done;
    wire done_clr = st_q == SARSEQ_ST_SAMPLE || (w_c1 &&
        !bus_i.wdata[SARSEQ_B_DONE]);
    wire sample_active_now = st_q == SARSEQ_ST_SAMPLE ||
        (st_q == SARSEQ_ST_CONVERT && 1'b0);
    logic [15:0] ctrl1_d;
    always_comb begin
        ctrl1_d = w_c1 ? (bus_i.wdata & SARSEQ_CTRL1_WMASK) : ctrl1_q;
        ctrl1_d[SARSEQ_B_SAMPLE_ACTIVE] = module_on ? sample_active_now : 1'b0;
        if (done_set) begin
            ctrl1_d[SARSEQ_B_DONE] = 1'b1;
        end else if (done_clr) begin
            ctrl1_d[SARSEQ_B_DONE] = 1'b0;
        end else begin
            ctrl1_d[SARSEQ_B_DONE] = ctrl1_q[SARSEQ_B_DONE];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl1_q <= SARSEQ_CTRL1_RST;
            ctrl2_q <= SARSEQ_CTRL2_RST;
            ctrl3_q <= SARSEQ_CTRL3_RST;
        end else begin
            ctrl1_q <= ctrl1_d;
            if (bus_i.wr && sel_c2) ctrl2_q <= bus_i.wdata &
                SARSEQ_CTRL2_WMASK;
            if (bus_i.wr && sel_c3) ctrl3_q <= bus_i.wdata &
                SARSEQ_CTRL3_WMASK;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_q <= 4'h0;
            fill_q <= 1'b0;
            seq_cnt_q <= 4'h0;
            alt_b_q <= 1'b0;
        end else if (!module_on) begin
            wptr_q <= 4'h0;
            fill_q <= 1'b0;
            seq_cnt_q <= 4'h0;
            alt_b_q <= 1'b0;
        end else if (conv_done) begin
            alt_b_q <= ctrl2_q[SARSEQ_B_ALT] && !alt_b_q;
            if (seq_last) begin
                seq_cnt_q <= 4'h0;
                wptr_q <= 4'h0;
                fill_q <= split_buffer_mode && !fill_q;
            end else begin
                seq_cnt_q <= seq_cnt_q + 4'h1;
                wptr_q <= split_buffer_mode ? {1'b0, wptr_q[2:0] + 3'h1} :
                    wptr_q + 4'h1;
            end
        end
    end

    // Storage array is cleared while off, so stale results never leak
    for (genvar gi = 0; gi < BUF_DEPTH; gi++) begin : g_buf
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                buf_q[gi] <= 16'h0000;
            end else if (!module_on) begin
                buf_q[gi] <= 16'h0000;
            end else if (conv_done && waddr == 4'(gi)) begin
                buf_q[gi] <= fmt_word;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_q <= 1'b0;
        end else if (irq_event) begin
            irq_q <= 1'b1;
        end else if (bus_i.wr && sel_irq && bus_i.wdata[0]) begin
            irq_q <= 1'b0;
        end
    end

    wire [15:0] ctrl2_rd = {ctrl2_q[15:8], fill_q, ctrl2_q[6:0]};
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (sel_buf) rd_mux = buf_q[{1'b0, bus_i.addr[2:0]} << 1 |
            4'h0];
        else if (sel_c1) rd_mux = ctrl1_q;
        else if (sel_c2) rd_mux = ctrl2_rd;
        else if (sel_c3) rd_mux = ctrl3_q;
        else if (sel_irq) rd_mux = {15'h0000, irq_q};
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= bus_i.rd ? rd_mux : 16'h0000;
        end
    end

    assign rdata_o = rdata_q;
    assign sample_o = st_q == SARSEQ_ST_SAMPLE;
    assign use_mux_b_o = alt_b_q;
    assign scan_step_o = conv_done && ctrl2_q[SARSEQ_B_SCAN];
    // Codes 1xx fall back to supply and ground
    assign vref_pos_neg_o = reference_select[2] ? 2'h0 :
        reference_select[1:0];
    assign conversion_irq_flag_o = irq_q;
endmodule : sarseq_top

// ==== test/sarseq_top_asserts.sv ====
// Port-level checks for the converter sequencer
`timescale 1ns/1ps
module sarseq_top_asserts
    import sarseq_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire sarseq_bus_s bus_i,
    input wire logic [15:0] rdata_o,
    input wire logic device_idle_i,
    input wire logic sample_o,
    input wire logic use_mux_b_o,
    input wire logic scan_step_o,
    input wire logic [1:0] vref_pos_neg_o,
    input wire logic conversion_irq_flag_o
);
    logic [15:0] c1_q;
    logic [15:0] c2_q;
    wire logic wr1_w = bus_i.wr && bus_i.addr == SARSEQ_OFS_CTRL1;
    wire logic wr2_w = bus_i.wr && bus_i.addr == SARSEQ_OFS_CTRL2;
    wire logic clr_w = bus_i.wr && bus_i.addr == SARSEQ_OFS_IRQ;
    wire logic on_w = c1_q[15];
    // Shadow copies only; hardware-owned bits are never looked at
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c1_q <= 16'h0000;
            c2_q <= 16'h0000;
        end else begin
            if (wr1_w) c1_q <= bus_i.wdata;
            if (wr2_w) c2_q <= bus_i.wdata;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_off; !on_w [*2] |-> !sample_o; endproperty
    a_off: assert property (p_off) else $error("sampling while off");
    property p_irq_on; $rose(conversion_irq_flag_o) |-> on_w; endproperty
    a_irq_on: assert property (p_irq_on) else $error("flag while off");
    property p_vref;
        vref_pos_neg_o == (c2_q[15] ? 2'h0 : c2_q[14:13]);
    endproperty
    a_vref: assert property (p_vref) else $error("reference pick");
    property p_irq_hold;
        conversion_irq_flag_o && on_w && !clr_w && !wr1_w
            |=> conversion_irq_flag_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
    property p_idle;
        (on_w && c1_q[13] && device_idle_i) [*2]
            |=> !$rose(conversion_irq_flag_o);
    endproperty
    a_idle: assert property (p_idle) else $error("ran in idle");
    property p_scan; scan_step_o |-> c2_q[10]; endproperty
    a_scan: assert property (p_scan) else $error("scan step");
    property p_alt; !c2_q[0] [*2] |-> !use_mux_b_o; endproperty
    a_alt: assert property (p_alt) else $error("mux b used");
    property p_fill;
        $past(bus_i.rd) && $past(bus_i.addr) == SARSEQ_OFS_CTRL2 && !c2_q[1]
            |-> !rdata_o[7];
    endproperty
    a_fill: assert property (p_fill) else $error("fill status");
    property p_lost;
        !on_w [*2] ##0 (bus_i.rd && bus_i.addr[3]) |=> rdata_o == 16'h0000;
    endproperty
    a_lost: assert property (p_lost) else $error("buffer kept");
    c_irq: cover property ($rose(conversion_irq_flag_o));
    c_mux: cover property ($rose(use_mux_b_o));
    c_scan: cover property (scan_step_o);
endmodule : sarseq_top_asserts
bind sarseq_top sarseq_top_asserts sarseq_top_asserts_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .device_idle_i(device_idle_i), .sample_o(sample_o),
    .use_mux_b_o(use_mux_b_o), .scan_step_o(scan_step_o),
    .vref_pos_neg_o(vref_pos_neg_o),
    .conversion_irq_flag_o(conversion_irq_flag_o));

// ==== test/sarseq_front_end.sv ====
// Analog input model: tracks while sampling, holds otherwise
`timescale 1ns/1ps
module sarseq_front_end (
    input wire logic clk_sys_i,
    input wire logic sample_i,
    output logic [9:0] result_o
);
    integer seed = 86;
    initial result_o = 10'h155;
    // Wanders every cycle while tracking, so a late capture shows
    always @(posedge clk_sys_i) begin
        if (sample_i) result_o <= 10'($random(seed));
    end
endmodule : sarseq_front_end

// ==== test/tb_top.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top
    import sarseq_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    sarseq_bus_s bus_i = '0;
    sarseq_trig_s trig_i = '0;
    logic device_idle_i = 1'b0;
    logic rc_tick_i = 1'b0;
    logic [9:0] sar_result_i;
    logic [15:0] rdata_o;
    logic sample_o;
    logic use_mux_b_o;
    logic scan_step_o;
    logic [1:0] vref_pos_neg_o;
    logic irq;
    logic prev_s = 1'b0;
    logic [9:0] res_q[$];
    logic mux_q[$];
    logic [15:0] v;
    int rc_cnt = 0;
    int errors = 0;
    int samples_checked = 0;
    sarseq_top #(.BUF_DEPTH(16)) sarseq_top_i (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .trig_i(trig_i), .device_idle_i(device_idle_i),
        .rc_tick_i(rc_tick_i), .sar_result_i(sar_result_i),
        .sample_o(sample_o), .use_mux_b_o(use_mux_b_o),
        .scan_step_o(scan_step_o), .vref_pos_neg_o(vref_pos_neg_o),
        .conversion_irq_flag_o(irq));
    sarseq_front_end sarseq_front_end_i (.clk_sys_i(clk_sys_i),
        .sample_i(sample_o), .result_o(sar_result_i));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // Capture what the hold stage froze at each end of sampling
    always @(posedge clk_sys_i) begin
        prev_s <= sample_o;
        rc_cnt <= rc_cnt + 1;
        rc_tick_i <= (rc_cnt % 4 == 3);
        if (prev_s && !sample_o) res_q.push_back(sar_result_i);
        if (!prev_s && sample_o) mux_q.push_back(use_mux_b_o);
    end
    function automatic logic [15:0] fmt(input logic [9:0] r,
                                        input logic [1:0] f);
        case (f)
            2'h0: fmt = {6'h00, r};
            2'h1: fmt = {{7{~r[9]}}, r[8:0]};
            2'h2: fmt = {r, 6'h00};
            default: fmt = {~r[9], r[8:0], 6'h00};
        endcase
    endfunction : fmt
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
            errors++;
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus_i <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus_i <= '0;
        @(negedge clk_sys_i);
        v = rdata_o;
    endtask : rd
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        chk(v, e);
    endtask : rchk
    task automatic wait_irq(input int lim);
        int n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask : wait_irq
    task automatic conv(input logic [15:0] c1, input logic [3:0] t);
        int n = 0;
        wr(SARSEQ_OFS_CTRL1, c1);
        wr(SARSEQ_OFS_CTRL1, c1 | 16'h0002);
        repeat (3) @(negedge clk_sys_i);
        chk({15'h0, sample_o}, 16'h0001);
        if (t == 4'h0) begin
            wr(SARSEQ_OFS_CTRL1, c1);
        end else begin
            @(posedge clk_sys_i);
            trig_i <= t;
            @(posedge clk_sys_i);
            trig_i <= '0;
        end
        v = 16'h0000;
        // Poll without counting the not-yet-done reads as mismatches
        while (v[0] !== 1'b1 && n < 300) begin
            rd(SARSEQ_OFS_CTRL1);
            n++;
        end
        chk(v, c1 | 16'h0001);
        rchk(SARSEQ_OFS_BUF, fmt(res_q.pop_front(), c1[9:8]));
        chk({15'h0, irq}, 16'h0001);
        wr(SARSEQ_OFS_IRQ, 16'h0001);
        wr(SARSEQ_OFS_CTRL1, 16'h0000);
    endtask : conv
    task automatic report_and_stop;
        $display("checked=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rchk(SARSEQ_OFS_CTRL1, 16'h0000);
        rchk(4'h1, 16'h0000);
        wr(SARSEQ_OFS_CTRL2, 16'hffff);
        rchk(SARSEQ_OFS_CTRL2, 16'he43f);
        wr(SARSEQ_OFS_CTRL3, 16'hff3f);
        rchk(SARSEQ_OFS_CTRL3, 16'h9f3f);
        for (int i = 0; i < 8; i++) begin
            wr(SARSEQ_OFS_CTRL2, 16'(i << 13));
            @(negedge clk_sys_i);
            chk(16'(vref_pos_neg_o), i[2] ? 16'h0 : 16'(i[1:0]));
        end
        $display("registers done");
        wr(SARSEQ_OFS_CTRL2, 16'h0000);
        wr(SARSEQ_OFS_CTRL3, 16'h0000);
        for (int f = 0; f < 4; f++) conv(16'h8000 | 16'(f << 8), 4'h0);
        $display("formats done");
        // Slow internal clock, scan on, external pin, both timer and CTU trigger sources
        wr(SARSEQ_OFS_CTRL3, 16'h8000);
        wr(SARSEQ_OFS_CTRL2, 16'h0400);
        conv(16'h8020, 4'h1);
        conv(16'h8140, 4'h8);
        conv(16'h8280, 4'h4);
        conv(16'h83c0, 4'h2);
        $display("triggers done");
        wr(SARSEQ_OFS_CTRL3, 16'h0200);
        wr(SARSEQ_OFS_CTRL2, 16'h0009);
        res_q.delete();
        mux_q.delete();
        wr(SARSEQ_OFS_CTRL1, 16'h80e4);
        wr(SARSEQ_OFS_CTRL1, 16'h80e6);
        wait_irq(400);
        chk(16'(res_q.size()), 16'h0003);
        rchk(SARSEQ_OFS_BUF, fmt(res_q[0], 2'h0));
        rchk(4'h9, fmt(res_q[2], 2'h0));
        chk({13'h0, mux_q[0], mux_q[1], mux_q[2]}, 16'h0002);
        wr(SARSEQ_OFS_IRQ, 16'h0001);
        wr(SARSEQ_OFS_CTRL1, 16'h0000);
        rchk(SARSEQ_OFS_BUF, 16'h0000);
        $display("auto done");
        wr(SARSEQ_OFS_CTRL1, 16'ha0e4);
        wr(SARSEQ_OFS_CTRL1, 16'ha0e6);
        device_idle_i <= 1'b1;
        repeat (300) @(negedge clk_sys_i);
        chk({15'h0, irq}, 16'h0000);
        @(posedge clk_sys_i);
        device_idle_i <= 1'b0;
        wait_irq(400);
        chk({15'h0, irq}, 16'h0001);
        wr(SARSEQ_OFS_CTRL1, 16'h0000);
        $display("idle done");
        report_and_stop();
    end
endmodule : tb_top
